// >>> hdl/pwm_db_top.sv
// What this block does
// - Active shutdown drives both phase outputs low.
// - input_select upper nibble picks shutdown source, lower nibble picks block clock.
// - function_config bit 7 inverts the incoming shutdown signal.
// - Two-bit shutdown mode: sync restart, disabled, or asynchronous.
// - Each phase routes to one of four global buses by its two-bit field.
// - output_select top bits choose how the block clock is synchronised.
// - Down counter value is readable by software.
// - Period register is write only; cycle lasts period plus one block clocks.
// - Compare width register is read/write and sets pulse width.
// - control_primary bit 0 enables the modulator.
// - control_primary upper nibble selects start source from sixteen inputs.
// - control_primary bit 2 selects the interrupt event.
// - control_primary bit 3 selects output edge alignment.
// - control_primary bit 1 enables software triggering.
// - control_secondary upper nibble holds the writable multi-shot count.
// - control_secondary bit 3 inverts an incoming input signal.
// - Three-bit dead time gives 0..64 block clocks; zero disables protection.
// - Dead time codes 0..7 map to 0,1,2,4,8,16,32,64.
// - Nonzero multi-shot halts output after last shot until enable rewritten.
// - Edge alignment delays the compare output for finer resolution.
`timescale 1ns/1ps
module pwm_db_top
  import pwm_db_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Candidate sources from outside the clock domain
  input wire logic [15:0] BLK_CLK_SRC_I,
  input wire logic [15:0] SHUTDOWN_SRC_I,
  input wire logic [15:0] START_SRC_I,
  // Outputs
  output logic FIRST_PHASE_O,
  output logic SECOND_PHASE_O,
  output logic [3:0] GLOBAL_OUT_O,
  output logic IRQ_EVENT_O
);

  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  // Registers
  logic [7:0] func_q, insel_q, outsel_q, period_q, width_q, ctrl0_q, ctrl1_q;
  logic [7:0] cnt_q;
  logic [3:0] shots_q;

  // Two-flop synchronisers for all external sources
  logic [47:0] sync1_q, sync2_q;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {START_SRC_I, SHUTDOWN_SRC_I, BLK_CLK_SRC_I};
      sync2_q <= sync1_q;
    end
  end

  logic [15:0] clk_s, sd_s, st_s;
  assign clk_s = sync2_q[15:0];
  assign sd_s = sync2_q[31:16];
  assign st_s = sync2_q[47:32];

  // Block clock enable
  logic clk_sel_s, clk_prev_q, tick;
  assign clk_sel_s = clk_s[insel_q[3:0]];
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) clk_prev_q <= 1'b0;
    else clk_prev_q <= clk_sel_s;
  end
  // Bypass runs the block at the bus clock; otherwise a synchronised edge
  assign tick = outsel_q[OS_SYNC_LO + CS_BYPASS] | (clk_sel_s & ~clk_prev_q);

  // Start gating
  logic start_s, run;
  assign start_s = st_s[ctrl0_q[7:C0_START_LO]] ^ ctrl1_q[C1_SINV];
  assign run = ctrl0_q[C0_EN] & (ctrl0_q[C0_SWT] | start_s);

  // AXI4-Lite slave
  logic aw_have_q, w_have_q, bvalid_q, arready_q, awready_q, wready_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_be_q, wr_fire, wr_ok;
  logic [7:0] wa;
  assign wa = 8'(aw_addr_q);
  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_ok = wr_fire & w_be_q;

  function automatic logic mapped(input logic [7:0] a);
    return a inside {OFS_FUNC, OFS_INSEL, OFS_OUTSEL, OFS_COUNT,
                     OFS_PERIOD, OFS_WIDTH, OFS_CTRL0, OFS_CTRL1};
  endfunction

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else begin
      awready_q <= AWVALID_I & ~awready_q & ~aw_have_q & ~bvalid_q;
      if (AWVALID_I & awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= AWADDR_I;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= RST_BYTE;
      w_be_q <= 1'b0;
    end else begin
      wready_q <= WVALID_I & ~wready_q & ~w_have_q & ~bvalid_q;
      if (WVALID_I & wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= WDATA_I[7:0];
        w_be_q <= WSTRB_I[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      bvalid_q <= 1'b0;
      BRESP_O <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      BRESP_O <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY_I) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read path: data captured on the address handshake
  logic [7:0] ra, rd_byte;
  assign ra = 8'(ARADDR_I);
  always_comb begin
    rd_byte = RST_BYTE;
    unique case (ra)
      OFS_FUNC: rd_byte = (func_q & FUNC_RW) | FUNC_FIXED;
      OFS_INSEL: rd_byte = insel_q;
      OFS_OUTSEL: rd_byte = outsel_q | OUTSEL_FIXED;
      OFS_COUNT: rd_byte = cnt_q;
      OFS_WIDTH: rd_byte = width_q;
      OFS_CTRL0: rd_byte = ctrl0_q;
      OFS_CTRL1: rd_byte = ctrl1_q;
      default: rd_byte = RST_BYTE; // period is write only
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= RESP_OKAY;
    end else begin
      arready_q <= ARVALID_I & ~arready_q & ~rvalid_q;
      if (ARVALID_I & arready_q) begin
        rvalid_q <= 1'b1;
        RDATA_O <= {24'h00_0000, rd_byte};
        RRESP_O <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY_I) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign AWREADY_O = awready_q;
  assign WREADY_O = wready_q;
  assign BVALID_O = bvalid_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;

  // Configuration registers
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      func_q <= RST_BYTE;
      insel_q <= RST_BYTE;
      outsel_q <= RST_BYTE;
      period_q <= RST_BYTE;
      width_q <= RST_BYTE;
      ctrl1_q <= RST_BYTE;
    end else if (wr_ok) begin
      if (wa == OFS_FUNC) func_q <= w_data_q;
      if (wa == OFS_INSEL) insel_q <= w_data_q;
      if (wa == OFS_OUTSEL) outsel_q <= w_data_q;
      if (wa == OFS_PERIOD) period_q <= w_data_q;
      if (wa == OFS_WIDTH) width_q <= w_data_q;
      if (wa == OFS_CTRL1) ctrl1_q <= w_data_q;
    end
  end

  // Counter and terminal count
  logic tc;
  assign tc = run & tick & (cnt_q == CNT_ZERO);
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      cnt_q <= RST_BYTE;
    end else if (wr_ok && wa == OFS_PERIOD && !run) begin
      cnt_q <= w_data_q;
    end else if (run && tick) begin
      cnt_q <= (cnt_q == CNT_ZERO) ? period_q : cnt_q - CNT_ONE;
    end
  end

  // Enable and multi-shot; a software write of enable beats the halt
  logic en_wr;
  assign en_wr = wr_ok && wa == OFS_CTRL0;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ctrl0_q <= RST_BYTE;
      shots_q <= RST_NIB;
    end else if (en_wr) begin
      ctrl0_q <= w_data_q;
      shots_q <= ctrl1_q[7:C1_MS_LO];
    end else if (tc && ctrl1_q[7:C1_MS_LO] != RST_NIB) begin
      shots_q <= shots_q - SHOT_ONE;
      if (shots_q <= SHOT_ONE) ctrl0_q[C0_EN] <= 1'b0;
    end
  end

  // Compare with optional extra delay stage
  logic pwm_q, pwm_dly_q, pwm_use, pwm_prev_q;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pwm_q <= 1'b0;
      pwm_dly_q <= 1'b0;
    end else begin
      pwm_q <= run & (cnt_q <= width_q);
      pwm_dly_q <= pwm_q;
    end
  end
  // Finest delay available on a single clock is one bus clock
  assign pwm_use = ctrl0_q[C0_ALIGN] ? pwm_dly_q : pwm_q;

  // Dead band counter
  logic [7:0] dt_len, dcnt_q;
  logic settled;
  assign dt_len = dead_len(ctrl1_q[2:C1_DT_LO]);
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      dcnt_q <= RST_BYTE;
      pwm_prev_q <= 1'b0;
    end else begin
      pwm_prev_q <= pwm_use;
      if (pwm_use != pwm_prev_q) dcnt_q <= CNT_ZERO;
      else if (tick && dcnt_q < dt_len) dcnt_q <= dcnt_q + CNT_ONE;
    end
  end
  // The counter restarts one clock after the edge, so that clock already counts
  assign settled = (dt_len == CNT_ZERO)
                 | ((pwm_use == pwm_prev_q) & (dcnt_q >= dt_len - CNT_ONE));

  // Shutdown handling
  logic sd_in, kill_latch_q, kill_act, kill_prev_q;
  assign sd_in = sd_s[insel_q[7:4]] ^ func_q[FN_INV];
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) kill_latch_q <= 1'b0;
    else if (sd_in) kill_latch_q <= 1'b1;
    else if (tc) kill_latch_q <= 1'b0;
  end
  always_comb begin
    unique case (func_q[FN_MODE_LO+1:FN_MODE_LO])
      SD_SYNC_RESTART: kill_act = sd_in | kill_latch_q;
      SD_DISABLED: kill_act = 1'b0;
      default: kill_act = sd_in;
    endcase
  end

  // Phase outputs
  logic p1_d, p2_d;
  assign p1_d = run & ~kill_act & pwm_use & settled;
  assign p2_d = run & ~kill_act & ~pwm_use & settled;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      FIRST_PHASE_O <= 1'b0;
      SECOND_PHASE_O <= 1'b0;
    end else begin
      FIRST_PHASE_O <= p1_d;
      SECOND_PHASE_O <= p2_d;
    end
  end

  // Global bus routing
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) GLOBAL_OUT_O <= RST_NIB;
    else begin
      for (int k = 0; k < 4; k++) begin
        GLOBAL_OUT_O[k] <= (p1_d & (outsel_q[OS_P1_LO+:2] == 2'(k)))
                         | (p2_d & (outsel_q[OS_P2_LO+:2] == 2'(k)));
      end
    end
  end

  // Interrupt event pulse
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      kill_prev_q <= 1'b0;
      IRQ_EVENT_O <= 1'b0;
    end else begin
      kill_prev_q <= kill_act;
      IRQ_EVENT_O <= ctrl0_q[C0_ITYPE] ? (kill_act & ~kill_prev_q) : tc;
    end
  end

  // Checks
  sequence s_tc;
    run && tick && cnt_q == CNT_ZERO;
  endsequence
  sequence s_rd_count;
    ARVALID_I && arready_q && ra == OFS_COUNT;
  endsequence

  property p_kill_low;
    @(posedge CLK_I) disable iff (!RSTN_I) kill_act |=> !FIRST_PHASE_O && !SECOND_PHASE_O;
  endproperty
  a_kill_low: assert property (p_kill_low) else $error("phase high during shutdown");

  property p_mode_off;
    @(posedge CLK_I) disable iff (!RSTN_I)
      func_q[FN_MODE_LO+1:FN_MODE_LO] == SD_DISABLED && run && pwm_use && settled
      |=> FIRST_PHASE_O;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("shutdown acted while disabled");

  property p_reload;
    @(posedge CLK_I) disable iff (!RSTN_I) s_tc |=> cnt_q == $past(period_q);
  endproperty
  a_reload: assert property (p_reload) else $error("counter did not reload");

  property p_count_rd;
    @(posedge CLK_I) disable iff (!RSTN_I) s_rd_count |=> RVALID_O && RDATA_O[7:0] == $past(cnt_q);
  endproperty
  a_count_rd: assert property (p_count_rd) else $error("count read mismatch");

  property p_stop_low;
    @(posedge CLK_I) disable iff (!RSTN_I) !run [*2] |=> !FIRST_PHASE_O && !SECOND_PHASE_O;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("phase high while stopped");

  property p_no_overlap;
    @(posedge CLK_I) disable iff (!RSTN_I) !(FIRST_PHASE_O && SECOND_PHASE_O);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("phases overlap");

  property p_dead_map;
    @(posedge CLK_I) disable iff (!RSTN_I)
      ctrl1_q[2:0] != 3'h0 |-> dt_len == (CNT_ONE << (ctrl1_q[2:0] - 3'h1));
  endproperty
  a_dead_map: assert property (p_dead_map) else $error("dead time map wrong");

  property p_last_shot;
    @(posedge CLK_I) disable iff (!RSTN_I)
      s_tc ##0 (ctrl1_q[7:4] != RST_NIB && shots_q <= SHOT_ONE && !en_wr) |=> !ctrl0_q[C0_EN];
  endproperty
  a_last_shot: assert property (p_last_shot) else $error("output not halted after last shot");

  property p_align;
    @(posedge CLK_I) disable iff (!RSTN_I) ctrl0_q[C0_ALIGN] |-> pwm_use == $past(pwm_q);
  endproperty
  a_align: assert property (p_align) else $error("edge alignment delay missing");

endmodule // pwm_db_top

// >>> shared/pwm_db_pkg.sv
package pwm_db_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FUNC = 8'h00;
  localparam logic [7:0] OFS_INSEL = 8'h04;
  localparam logic [7:0] OFS_OUTSEL = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_WIDTH = 8'h14;
  localparam logic [7:0] OFS_CTRL0 = 8'h18;
  localparam logic [7:0] OFS_CTRL1 = 8'h1C;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  // Fixed read-back bits of function_config and output_select
  localparam logic [7:0] FUNC_FIXED = 8'h23;
  localparam logic [7:0] OUTSEL_FIXED = 8'h24;
  // Bits of function_config that software can change; bits 6 and 2 always read 0
  localparam logic [7:0] FUNC_RW = 8'h98;
  // function_config fields
  localparam int FN_INV = 7;
  localparam int FN_MODE_LO = 3;
  // output_select fields
  localparam int OS_SYNC_HI = 7;
  localparam int OS_SYNC_LO = 6;
  localparam int OS_P2_LO = 3;
  localparam int OS_P1_LO = 0;
  // control_primary fields
  localparam int C0_EN = 0;
  localparam int C0_SWT = 1;
  localparam int C0_ITYPE = 2;
  localparam int C0_ALIGN = 3;
  localparam int C0_START_LO = 4;
  // control_secondary fields
  localparam int C1_DT_LO = 0;
  localparam int C1_SINV = 3;
  localparam int C1_MS_LO = 4;
  // Shutdown mode encodings
  localparam logic [1:0] SD_SYNC_RESTART = 2'h0;
  localparam logic [1:0] SD_DISABLED = 2'h1;
  localparam logic [1:0] SD_ASYNC = 2'h2;
  // clock_sync_sel: top bit set runs the block at the bus clock rate
  localparam int CS_BYPASS = 1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [3:0] SHOT_ONE = 4'h1;

  // Dead time code to block clocks: 0,1,2,4,...,64
  function automatic logic [7:0] dead_len(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    if (code != 3'h0) begin
      r = CNT_ONE << (code - 3'h1);
    end
    return r;
  endfunction
endpackage

// >>> sim/deadband_pwm_register_map_test.sv
`timescale 1ns/1ps
module deadband_pwm_register_map_test;
  import pwm_db_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic kill = 1'b0;
  logic start = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, p1, p2, irq, ovl;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] gout;
  logic [15:0] blk, ksrc, ssrc;
  logic [33:0] exp_q[$];
  logic [7:0] lf = 8'h63;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int h1, h2, ni, g1, g2, dl;

  pwm_db_top dut_u (.CLK_I(clk), .RSTN_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(1'b1),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(1'b1), .BLK_CLK_SRC_I(blk),
    .SHUTDOWN_SRC_I(ksrc), .START_SRC_I(ssrc), .FIRST_PHASE_O(p1),
    .SECOND_PHASE_O(p2), .GLOBAL_OUT_O(gout), .IRQ_EVENT_O(irq));
  pwm_stage_model stage_u (.clk_i(clk), .rst_n_i(rst_n), .p1_i(p1), .p2_i(p2),
    .kill_i(kill), .start_i(start), .blk_o(blk), .kill_o(ksrc), .start_o(ssrc),
    .overlap_o(ovl));

  always #4 clk = ~clk;

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Ceiling well above the roughly 6200 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t run hung", $time);
      conclude();
    end
  end

  // Responses are checked in issue order against the notes of the driver
  always @(posedge clk) begin
    if (bvalid) chk({bresp, 32'h0000_0000}, exp_q.pop_front());
    if (rvalid) chk({rresp, rdata}, exp_q.pop_front());
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic aw, w;
    exp_q.push_back({r, 32'h0000_0000});
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    exp_q.push_back({r, 24'h00_0000, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
  endtask

  task automatic meas(input int n);
    h1 = 0;
    h2 = 0;
    ni = 0;
    g1 = 0;
    g2 = 0;
    repeat (n) begin
      @(posedge clk);
      h1 += p1;
      h2 += p2;
      ni += irq;
      g1 += gout[1];
      g2 += gout[2];
    end
  endtask

  // Stop, load dead time and function, restart; dead time loads even while running
  task automatic run(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] f);
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_CTRL1, c1);
    wr(OFS_FUNC, f);
    wr(OFS_CTRL0, c0);
    repeat (200) @(posedge clk);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), (i == 0) ? FUNC_FIXED : (i == 2) ? OUTSEL_FIXED : RST_BYTE);
    end
    rd(8'h20, 8'h00, RESP_SLVERR);
    wr(8'h20, 8'h55, RESP_SLVERR);
    repeat (4) begin
      lf = lfsr(lf);
      wr(OFS_WIDTH, lf);
      rd(OFS_WIDTH, lf);
      wr(OFS_CTRL1, lf);
      rd(OFS_CTRL1, lf);
      wr(OFS_INSEL, lf);
      rd(OFS_INSEL, lf);
      wr(OFS_FUNC, lf);
      rd(OFS_FUNC, (lf & 8'h98) | FUNC_FIXED);
      wr(OFS_OUTSEL, lf);
      rd(OFS_OUTSEL, (lf & 8'hDB) | OUTSEL_FIXED);
      wr(OFS_PERIOD, lf);
      rd(OFS_PERIOD, RST_BYTE);
      rd(OFS_COUNT, lf);
    end
    // Phase 1 on bus 2, phase 2 on bus 1, tick every clock
    wr(OFS_OUTSEL, 8'h8A);
    wr(OFS_INSEL, 8'h00);
    wr(OFS_PERIOD, 8'h09);
    wr(OFS_WIDTH, 8'h04);
    run(8'h31, 8'h00, 8'h00);
    meas(100);
    chk(34'(h1 + ni), 34'(0));
    start <= 1'b1;
    repeat (50) @(posedge clk);
    meas(100);
    chk(34'(h1), 34'(50));
    chk(34'(ni), 34'(10));
    chk(34'(g2), 34'(50));
    chk(34'(g1), 34'(50));
    run(8'h31, 8'h08, 8'h00);
    meas(100);
    chk(34'(h1), 34'(0));
    // Synchronised source toggles every clock, so the block ticks every second clock
    wr(OFS_OUTSEL, 8'h0A);
    run(8'h03, 8'h00, 8'h00);
    meas(200);
    chk(34'(ni), 34'(10));
    chk(34'(h1), 34'(100));
    wr(OFS_OUTSEL, 8'h8A);
    wr(OFS_PERIOD, 8'h63);
    wr(OFS_WIDTH, 8'h4F);
    for (int d = 0; d < 6; d++) begin
      dl = (d == 0) ? 0 : (1 << (d - 1));
      run((d % 2 == 1) ? 8'h0B : 8'h03, 8'(d), 8'h00);
      meas(400);
      chk(34'(h1), 34'(4 * (80 - dl)));
      chk(34'(h2), 34'(4 * (20 - dl)));
    end
    wr(OFS_INSEL, 8'h50);
    run(8'h07, 8'h00, 8'h10);
    kill <= 1'b1;
    meas(8);
    chk(34'(ni), 34'(1));
    meas(100);
    chk(34'(h1 + h2), 34'(0));
    wr(OFS_FUNC, 8'h90);
    repeat (20) @(posedge clk);
    meas(100);
    chk(34'(h1), 34'(80));
    wr(OFS_FUNC, 8'h08);
    repeat (20) @(posedge clk);
    meas(100);
    chk(34'(h2), 34'(20));
    wr(OFS_FUNC, 8'h00);
    repeat (20) @(posedge clk);
    meas(100);
    chk(34'(h1 + h2), 34'(0));
    kill <= 1'b0;
    wr(OFS_CTRL0, 8'h00);
    wr(OFS_PERIOD, 8'h09);
    wr(OFS_CTRL1, 8'h30);
    repeat (2) begin
      wr(OFS_CTRL0, 8'h03);
      meas(100);
      chk(34'(ni), 34'(3));
      rd(OFS_CTRL0, 8'h02);
      meas(50);
      chk(34'(h1), 34'(0));
    end
    chk({33'h0_0000_0000, ovl}, 34'(0));
    conclude();
  end
endmodule // deadband_pwm_register_map_test

// >>> sim/pwm_stage_model.sv
`timescale 1ns/1ps
module pwm_stage_model (
  // Clock, reset and the two switch drives
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic p1_i,
  input wire logic p2_i,
  // Events commanded by the bench
  input wire logic kill_i,
  input wire logic start_i,
  // Lines back to the block
  output logic [15:0] blk_o,
  output logic [15:0] kill_o,
  output logic [15:0] start_o,
  output logic overlap_o
);
  // Source clocks keep toggling; the bench runs the bypass tick in all but one phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      blk_o <= 16'h0000;
    end else begin
      blk_o <= ~blk_o;
    end
  end
  // One candidate line per event, so a wrong select is seen
  assign kill_o = {10'h000, kill_i, 5'h00};
  assign start_o = {12'h000, start_i, 3'h0};
  // Both switches on at once would short the stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      overlap_o <= 1'b0;
    end else if (p1_i && p2_i) begin
      overlap_o <= 1'b1;
    end
  end
endmodule // pwm_stage_model
